// >>> core/adc_result_and_interrupt_handler.sv
// Functional notes
// [R1] result low byte: two lsbs in bits 7:6, bits 5:0 read zero
// [R2] result high byte: eight msbs in bits 7:0, read-only, reset zero
// [R3] reserved bits of result, status and mask registers read zero
// [R4] charger channel 1 result at 0x59 low and 0x5A high
// [R5] charger channel 4 result at 0x5F low and 0x60 high
// [R6] status bits: realtime 0, soft1 1, soft2 2, bus sequence 3
// [R7] writing one to status never creates a request
// [R8] writing one to a set status bit clears it
// [R9] writing zero to a status bit leaves it unchanged
// [R10] status and mask registers update on the register clock
// [R11] mask bit 1 blocks its source, 0 allows; all reset to 1
// [R12] interrupt output asserts while any unmasked status bit is set
// [R13] edge select 01 falling, 10 rising, 11 both
// [R14] edge select pairs: bus seq 7/6, soft2 5/4, soft1 3/2, realtime 1/0
// [R15] edge select resets to 0x55, falling edge everywhere
// [R16] pending drop set discards events arriving while flag still set
// [R17] clear mode bit: 1 clear on read, 0 clear by write
// [R18] clear on read: status read clears all and releases request
// [R19] write-clear mode: read of clear-all address clears all status
// [R20] done level is low while a sequence runs, high when done
// [R21] status bit sets the cycle after a selected edge, stays till cleared
// [R22] software writes control bit 0 back as one
`include "adc_irq_defines.svh"
`default_nettype none
module adc_result_and_interrupt_handler #(
  parameter int NSRC = `NUM_SOURCES,
  parameter int NRES = `NUM_RESULTS
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic [NSRC-1:0] seq_done_level,
  input wire logic [NRES-1:0] result_load,
  input wire logic [NRES*`RESULT_WIDTH-1:0] result_value,
  output logic sequence_irq_out
);

  adc_irq_pkg::handler_state_t st;
  adc_irq_pkg::handler_state_t nx;

  logic [NSRC-1:0] seq_event;
  logic [NSRC-1:0] clr;
  logic [7:0] rd_mux;
  logic [7:0] res_low [NRES];
  logic [7:0] res_high [NRES];
  logic pending_drop;
  logic clear_on_read_sel;
  logic rd_status;
  logic wr_status;
  logic rd_clear_all;

  if (NSRC != `NUM_SOURCES || NRES != `NUM_RESULTS) begin : g_bad_size
    $error("handler serves four sources and three result channels");
  end

  // done levels come from converter logic on mclk, no synchroniser needed
  seq_edge_detect #(
    .NSRC(NSRC)
  ) u_edge (
    .mclk(mclk),
    .rstn(rstn),
    .level(seq_done_level),
    .sel(st.edge_sel),
    .edge_hit(seq_event)
  );

  genvar r;
  generate
    for (r = 0; r < NRES; r++) begin : g_res
      result_hold #(
        .WIDTH(`RESULT_WIDTH)
      ) u_res (
        .mclk(mclk),
        .rstn(rstn),
        .load(result_load[r]),
        .value(result_value[r*`RESULT_WIDTH +: `RESULT_WIDTH]),
        .low_byte(res_low[r]),
        .high_byte(res_high[r])
      );
    end
  endgenerate

  assign pending_drop = st.ctrl[`CTRL_PENDING_DROP_BIT];
  assign clear_on_read_sel = st.ctrl[`CTRL_CLEAR_ON_READ_BIT];
  assign rd_status = reg_rd && (reg_addr == `SEQ_IRQ_STATUS_ADDR);
  assign wr_status = reg_wr && (reg_addr == `SEQ_IRQ_STATUS_ADDR);
  assign rd_clear_all = reg_rd && (reg_addr == `SEQ_IRQ_CLEAR_ALL_ADDR);

  // clear vector for this cycle
  always_comb begin
    clr = 4'h0;
    if (clear_on_read_sel) begin
      if (rd_status) begin
        clr = 4'hF; // [R18]
      end
    end else begin
      if (rd_clear_all) begin
        clr = 4'hF; // [R19]
      end
      if (wr_status) begin
        clr = clr | reg_wdata[3:0]; // [R8] [R9] [R17]
      end
    end
  end

  // read data reflects the state before this cycle's clear
  always_comb begin
    rd_mux = 8'h00;
    unique case (reg_addr)
      `GP12_RESULT_LOW_ADDR: rd_mux = res_low[adc_irq_pkg::RES_GP12];
      `GP12_RESULT_HIGH_ADDR: rd_mux = res_high[adc_irq_pkg::RES_GP12];
      `CHG1_RESULT_LOW_ADDR: rd_mux = res_low[adc_irq_pkg::RES_CHG1]; // [R4]
      `CHG1_RESULT_HIGH_ADDR: rd_mux = res_high[adc_irq_pkg::RES_CHG1]; // [R4]
      `CHG4_RESULT_LOW_ADDR: rd_mux = res_low[adc_irq_pkg::RES_CHG4]; // [R5]
      `CHG4_RESULT_HIGH_ADDR: rd_mux = res_high[adc_irq_pkg::RES_CHG4]; // [R5]
      `SEQ_IRQ_STATUS_ADDR: rd_mux = {4'h0, st.stat}; // [R3] [R6]
      `SEQ_IRQ_MASK_ADDR: rd_mux = {4'h0, st.mask}; // [R3]
      `SEQ_IRQ_EDGE_SEL_ADDR: rd_mux = st.edge_sel;
      `IRQ_HANDLER_CTRL_ADDR: rd_mux = {5'h00, st.ctrl};
      default: rd_mux = 8'h00;
    endcase
  end

  always_comb begin
    nx = st;
    // set wins over clear; a written one never sets
    nx.stat = (st.stat & ~clr) | seq_event | (st.pend & clr & st.stat); // [R7] [R21]
    // a second event during service waits, unless dropping is chosen
    nx.pend = (st.pend & ~(clr & st.stat)) |
              (seq_event & st.stat & ~clr & {NSRC{~pending_drop}}); // [R16]
    if (reg_wr) begin
      unique case (reg_addr)
        `SEQ_IRQ_MASK_ADDR: nx.mask = reg_wdata[3:0]; // [R11]
        `SEQ_IRQ_EDGE_SEL_ADDR: nx.edge_sel = reg_wdata; // [R14]
        // bit 0 is stored as written; software keeps it at one
        `IRQ_HANDLER_CTRL_ADDR: nx.ctrl = reg_wdata[2:0]; // [R17]
        default: nx.ctrl = st.ctrl;
      endcase
    end
    if (reg_rd) begin
      nx.rdata = rd_mux;
    end
    nx.irq = |(nx.stat & ~nx.mask); // [R11] [R12]
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      st.stat <= `STATUS_RESET;
      st.pend <= `STATUS_RESET;
      st.mask <= `MASK_RESET; // [R11]
      st.edge_sel <= `EDGE_SEL_RESET; // [R15]
      st.ctrl <= `CTRL_RESET; // [R16] [R17]
      st.rdata <= 8'h00;
      st.irq <= 1'b0;
    end else begin
      st <= nx; // [R10]
    end
  end

  assign reg_rdata = st.rdata;
  assign sequence_irq_out = st.irq;

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rstn);

  property p_event_sets;
    |seq_event |=> ((st.stat & $past(seq_event)) == $past(seq_event));
  endproperty
  a_event_sets: assert property (p_event_sets) else $error("event did not set flag"); // [R21]

  property p_w1c;
    (wr_status && !clear_on_read_sel && reg_wdata[0] && !seq_event[0] && !st.pend[0])
      |=> !st.stat[0];
  endproperty
  a_w1c: assert property (p_w1c) else $error("write one did not clear"); // [R8]

  property p_no_force;
    (wr_status && seq_event == 4'h0 && st.pend == 4'h0) |=> ((st.stat & ~$past(st.stat)) == 4'h0);
  endproperty
  a_no_force: assert property (p_no_force) else $error("write created request"); // [R7]

  property p_write_zero_keeps;
    (wr_status && !clear_on_read_sel && reg_wdata[3:0] == 4'h0)
      |=> ((st.stat & $past(st.stat)) == $past(st.stat));
  endproperty
  a_write_zero_keeps: assert property (p_write_zero_keeps) else $error("zero write cleared"); // [R9]

  property p_cor_read;
    (rd_status && clear_on_read_sel && seq_event == 4'h0 && st.pend == 4'h0)
      |=> (st.stat == 4'h0) && !sequence_irq_out;
  endproperty
  a_cor_read: assert property (p_cor_read) else $error("read did not clear"); // [R18]

  property p_clear_all;
    (rd_clear_all && !clear_on_read_sel && seq_event == 4'h0 && st.pend == 4'h0)
      |=> st.stat == 4'h0;
  endproperty
  a_clear_all: assert property (p_clear_all) else $error("clear-all read failed"); // [R19]

  property p_irq_follows;
    sequence_irq_out == (|(st.stat & ~st.mask));
  endproperty
  a_irq_follows: assert property (p_irq_follows) else $error("irq out of step"); // [R12]

  property p_drop;
    (pending_drop && seq_event[1] && st.stat[1] && !clr[1] && !st.pend[1]) |=> !st.pend[1];
  endproperty
  a_drop: assert property (p_drop) else $error("dropped event kept"); // [R16]

  property p_status_read;
    rd_status |=> (reg_rdata == {4'h0, $past(st.stat)});
  endproperty
  a_status_read: assert property (p_status_read) else $error("status read wrong"); // [R6]

  property p_mask_blocks;
    (st.mask == 4'hF) |-> !sequence_irq_out;
  endproperty
  a_mask_blocks: assert property (p_mask_blocks) else $error("masked irq seen"); // [R11]

  property p_mask_write;
    (reg_wr && reg_addr == `SEQ_IRQ_MASK_ADDR)
      |=> st.mask == $past(reg_wdata[3:0]);
  endproperty
  a_mask_write: assert property (p_mask_write) else $error("mask write lost"); // [R11]

  property p_edge_write;
    (reg_wr && reg_addr == `SEQ_IRQ_EDGE_SEL_ADDR)
      |=> st.edge_sel == $past(reg_wdata);
  endproperty
  a_edge_write: assert property (p_edge_write) else $error("edge select write lost"); // [R14]

  property p_ctrl_write;
    (reg_wr && reg_addr == `IRQ_HANDLER_CTRL_ADDR)
      |=> st.ctrl == $past(reg_wdata[2:0]);
  endproperty
  a_ctrl_write: assert property (p_ctrl_write) else $error("control write lost"); // [R17]

  property p_cor_write_ignored;
    (reg_wr && !reg_rd && reg_addr == `SEQ_IRQ_STATUS_ADDR && clear_on_read_sel)
      |=> ((st.stat & $past(st.stat)) == $past(st.stat));
  endproperty
  a_cor_write_ignored: assert property (p_cor_write_ignored) else $error("write cleared"); // [R17]

  property p_cor_clear_all_ignored;
    (rd_clear_all && clear_on_read_sel)
      |=> ((st.stat & $past(st.stat)) == $past(st.stat));
  endproperty
  a_cor_clear_all_ignored: assert property (p_cor_clear_all_ignored) else $error("bad clear"); // [R19]

  property p_pend_keep;
    (!pending_drop && seq_event[1] && st.stat[1] && !clr[1])
      |=> st.pend[1];
  endproperty
  a_pend_keep: assert property (p_pend_keep) else $error("second event lost"); // [R16]

  property p_pend_reload;
    (clr[1] && st.pend[1] && st.stat[1])
      |=> st.stat[1];
  endproperty
  a_pend_reload: assert property (p_pend_reload) else $error("pending event not reloaded"); // [R16]

  property p_drop_keeps_flag;
    (pending_drop && seq_event[1] && st.stat[1] && !clr[1])
      |=> st.stat[1];
  endproperty
  a_drop_keeps_flag: assert property (p_drop_keeps_flag) else $error("flag lost on drop"); // [R16]

  property p_stays_set;
    (st.stat[0] && !clr[0])
      |=> st.stat[0];
  endproperty
  a_stays_set: assert property (p_stays_set) else $error("flag fell without clear"); // [R21]

  property p_no_sel_no_set;
    (st.edge_sel[1:0] == 2'h0 && !st.stat[0])
      |=> !st.stat[0];
  endproperty
  a_no_sel_no_set: assert property (p_no_sel_no_set) else $error("flag set while disabled"); // [R13]

  // a mask write in the same cycle may legally hide the event
  property p_irq_rises;
    ((|(seq_event & ~st.mask)) && !(reg_wr && reg_addr == `SEQ_IRQ_MASK_ADDR))
      |=> sequence_irq_out;
  endproperty
  a_irq_rises: assert property (p_irq_rises) else $error("unmasked event gave no irq"); // [R12]

  property p_mask_read;
    (reg_rd && reg_addr == `SEQ_IRQ_MASK_ADDR)
      |=> reg_rdata == {4'h0, $past(st.mask)};
  endproperty
  a_mask_read: assert property (p_mask_read) else $error("mask read wrong"); // [R3]

  property p_ctrl_read;
    (reg_rd && reg_addr == `IRQ_HANDLER_CTRL_ADDR)
      |=> reg_rdata == {5'h00, $past(st.ctrl)};
  endproperty
  a_ctrl_read: assert property (p_ctrl_read) else $error("control read wrong"); // [R17]

  property p_edge_read;
    (reg_rd && reg_addr == `SEQ_IRQ_EDGE_SEL_ADDR)
      |=> reg_rdata == $past(st.edge_sel);
  endproperty
  a_edge_read: assert property (p_edge_read) else $error("edge select read wrong"); // [R14]

endmodule
`default_nettype wire

// >>> core/result_hold.sv
`include "adc_irq_defines.svh"
`default_nettype none
module result_hold #(
  parameter int WIDTH = `RESULT_WIDTH
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic load,
  input wire logic [WIDTH-1:0] value,
  output logic [7:0] low_byte,
  output logic [7:0] high_byte
);

  adc_irq_pkg::result_state_t st;
  adc_irq_pkg::result_state_t nx;

  if (WIDTH != `RESULT_WIDTH) begin : g_bad_width
    $error("result_hold is built for ten-bit results");
  end

  always_comb begin
    nx = st;
    if (load) begin
      nx.value = value;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      st.value <= `RESULT_RESET; // [R2]
    end else begin
      st <= nx;
    end
  end

  // two lsbs on top of the low byte, rest reads zero
  assign low_byte = {st.value[1:0], 6'h00}; // [R1] [R3]
  assign high_byte = st.value[9:2]; // [R2]

  property p_low_zero;
    @(posedge mclk) disable iff (!rstn)
      low_byte[5:0] == 6'h00;
  endproperty
  a_low_zero: assert property (p_low_zero) else $error("reserved low bits nonzero"); // [R3]

  property p_load_split;
    @(posedge mclk) disable iff (!rstn)
      load |=> (high_byte == $past(value[9:2])) && (low_byte[7:6] == $past(value[1:0]));
  endproperty
  a_load_split: assert property (p_load_split) else $error("result split wrong"); // [R1]

endmodule
`default_nettype wire

// >>> core/seq_edge_detect.sv
`include "adc_irq_defines.svh"
`default_nettype none
module seq_edge_detect #(
  parameter int NSRC = `NUM_SOURCES
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic [NSRC-1:0] level,
  input wire logic [2*NSRC-1:0] sel,
  output logic [NSRC-1:0] edge_hit
);

  adc_irq_pkg::edge_state_t st;
  adc_irq_pkg::edge_state_t nx;

  if (NSRC != `NUM_SOURCES) begin : g_bad_nsrc
    $error("seq_edge_detect serves exactly four sources");
  end

  always_comb begin
    nx = st;
    nx.prev = level;
  end

  // idle level is high, so no false edge right after reset
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      st.prev <= `LEVEL_IDLE; // [R20]
    end else begin
      st <= nx;
    end
  end

  genvar i;
  generate
    for (i = 0; i < NSRC; i++) begin : g_src
      // even bit selects falling, odd bit rising
      assign edge_hit[i] = (sel[2*i] & st.prev[i] & ~level[i]) |
                           (sel[2*i+1] & ~st.prev[i] & level[i]); // [R13] [R14]
    end
  endgenerate

  property p_fall_edge;
    @(posedge mclk) disable iff (!rstn)
      (sel[0] && st.prev[0] && !level[0]) |-> edge_hit[0];
  endproperty
  a_fall_edge: assert property (p_fall_edge) else $error("falling edge missed"); // [R13]

  property p_no_sel_no_hit;
    @(posedge mclk) disable iff (!rstn)
      (sel[7:6] == 2'h0) |-> !edge_hit[3];
  endproperty
  a_no_sel_no_hit: assert property (p_no_sel_no_hit) else $error("hit while disabled"); // [R13]

endmodule
`default_nettype wire

// >>> include/adc_irq_defines.svh
`ifndef ADC_IRQ_DEFINES_SVH
`define ADC_IRQ_DEFINES_SVH

// register offsets on the register port
`define GP12_RESULT_LOW_ADDR 8'h4F
`define GP12_RESULT_HIGH_ADDR 8'h50
`define CHG1_RESULT_LOW_ADDR 8'h59
`define CHG1_RESULT_HIGH_ADDR 8'h5A
`define CHG4_RESULT_LOW_ADDR 8'h5F
`define CHG4_RESULT_HIGH_ADDR 8'h60
`define SEQ_IRQ_STATUS_ADDR 8'h61
`define SEQ_IRQ_MASK_ADDR 8'h62
`define SEQ_IRQ_CLEAR_ALL_ADDR 8'h63
`define SEQ_IRQ_EDGE_SEL_ADDR 8'h66
`define IRQ_HANDLER_CTRL_ADDR 8'h67

// reset values
`define STATUS_RESET 4'h0
`define MASK_RESET 4'hF
`define EDGE_SEL_RESET 8'h55
`define CTRL_RESET 3'h7
`define RESULT_RESET 10'h000
`define LEVEL_IDLE 4'hF

// field positions, counts and widths
`define CTRL_KEEP_BIT 0
`define CTRL_PENDING_DROP_BIT 1
`define CTRL_CLEAR_ON_READ_BIT 2
`define RESULT_LOW_LSB 6
`define NUM_SOURCES 4
`define NUM_RESULTS 3
`define RESULT_WIDTH 10

`endif

// >>> include/adc_irq_pkg.sv
`default_nettype none
package adc_irq_pkg;

  typedef enum logic [1:0] {
    SRC_REALTIME = 2'h0,
    SRC_SOFT1 = 2'h1,
    SRC_SOFT2 = 2'h2,
    SRC_BUS_SEQ = 2'h3
  } source_t;

  typedef enum logic [1:0] {
    RES_GP12 = 2'h0,
    RES_CHG1 = 2'h1,
    RES_CHG4 = 2'h2
  } result_chan_t;

  typedef struct packed {
    logic [3:0] stat;
    logic [3:0] pend;
    logic [3:0] mask;
    logic [7:0] edge_sel;
    logic [2:0] ctrl;
    logic [7:0] rdata;
    logic irq;
  } handler_state_t;

  typedef struct packed {
    logic [3:0] prev;
  } edge_state_t;

  typedef struct packed {
    logic [9:0] value;
  } result_state_t;

endpackage
`default_nettype wire

// >>> tb/host_reg_model.sv
`include "adc_irq_defines.svh"
`default_nettype none
module host_reg_model (
  input wire logic mclk,
  output logic [7:0] reg_addr,
  output logic reg_wr,
  output logic reg_rd,
  output logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    reg_addr = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_wdata = 8'h00;
  end
  // released lines show the inverse so stale values never pass for data
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [7:0] d,
                      output logic [7:0] q);
    @(posedge mclk);
    #1;
    reg_addr = a;
    reg_wdata = d;
    reg_wr = wr;
    reg_rd = ~wr;
    @(posedge mclk);
    #1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
    @(posedge mclk);
    #1;
    q = reg_rdata;
  endtask
  // modes: bit1 clear on read, bit0 pending drop; bit0 of the register kept at one
  task automatic set_ctrl(input logic [1:0] modes);
    logic [7:0] q;
    xfer(1'b1, `IRQ_HANDLER_CTRL_ADDR, {5'h00, modes, 1'b1}, q);
  endtask
endmodule
`default_nettype wire

// >>> tb/tb_adc_result_and_interrupt_handler.sv
`include "adc_irq_defines.svh"
`default_nettype none
module tb_adc_result_and_interrupt_handler;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk;
  logic rstn;
  logic [7:0] reg_addr;
  logic reg_wr;
  logic reg_rd;
  logic [7:0] reg_wdata;
  logic [7:0] reg_rdata;
  logic [3:0] seq_done_level;
  logic [2:0] result_load;
  logic [29:0] result_value;
  logic sequence_irq_out;
  logic [7:0] q;
  logic [9:0] v;
  logic [1:0] sel;
  logic [7:0] esel;
  logic [7:0] exp_s;
  int src;
  int miscompares;
  int compares;
  logic [7:0] lo_addr [3] = '{`GP12_RESULT_LOW_ADDR, `CHG1_RESULT_LOW_ADDR, `CHG4_RESULT_LOW_ADDR};
  logic [7:0] hi_addr [3] = '{`GP12_RESULT_HIGH_ADDR, `CHG1_RESULT_HIGH_ADDR,
                              `CHG4_RESULT_HIGH_ADDR};

  adc_result_and_interrupt_handler dut_u (.mclk(mclk), .rstn(rstn), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .seq_done_level(seq_done_level), .result_load(result_load), .result_value(result_value),
    .sequence_irq_out(sequence_irq_out));
  host_reg_model host_u (.mclk(mclk), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  task automatic end_of_test;
    if (miscompares == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    compares++;
    if (g !== e) begin
      $display("[FAIL] %s expected %h seen %h", n, e, g);
      miscompares++;
    end
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e, input string n);
    host_u.xfer(1'b0, a, 8'h00, q);
    chk(n, e, q);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    host_u.xfer(1'b1, a, d, q);
  endtask

  // a few spare cycles so the edge lands in status before the next access
  task automatic pulse(input int s, input logic l);
    @(posedge mclk);
    #1;
    seq_done_level[s] = l;
    repeat (3) @(posedge mclk);
  endtask

  function automatic logic [7:0] ev(input logic [1:0] s, input int n, input logic o,
                                    input logic l);
    return 8'((s[0] & o & ~l) | (s[1] & ~o & l)) << n;
  endfunction

  initial begin
    repeat (20000) @(posedge mclk);
    miscompares++;
    end_of_test();
  end

  initial begin
    void'($urandom(17161));
    rstn = 1'b0;
    seq_done_level = 4'hF;
    result_load = 3'h0;
    result_value = 30'h0;
    repeat (12) @(posedge mclk);
    #1;
    rstn = 1'b1;
    rd_chk(`SEQ_IRQ_MASK_ADDR, 8'h0F, "mask reset");
    rd_chk(`SEQ_IRQ_EDGE_SEL_ADDR, 8'h55, "edge reset");
    rd_chk(`IRQ_HANDLER_CTRL_ADDR, 8'h07, "ctrl reset");
    rd_chk(`SEQ_IRQ_STATUS_ADDR, 8'h00, "status reset");
    rd_chk(`CHG1_RESULT_HIGH_ADDR, 8'h00, "result reset");
    rd_chk(8'h70, 8'h00, "unmapped read");
    for (int k = 0; k < 6; k++) begin
      v = (k < 3) ? 10'h3FF : 10'($urandom);
      @(posedge mclk);
      #1;
      result_value[(k % 3) * 10 +: 10] = v;
      result_load[k % 3] = 1'b1;
      @(posedge mclk);
      #1;
      result_load = 3'h0;
      wr(hi_addr[k % 3], ~v[9:2]);
      rd_chk(lo_addr[k % 3], {v[1:0], 6'h00}, "result low");
      rd_chk(hi_addr[k % 3], v[9:2], "result high");
    end
    wr(`SEQ_IRQ_MASK_ADDR, 8'hF0);
    rd_chk(`SEQ_IRQ_MASK_ADDR, 8'h00, "mask reserved");
    // every edge code on every source, then random sources
    for (int k = 0; k < 24; k++) begin
      src = (k < 16) ? k / 4 : int'($urandom % 4);
      sel = 2'(k % 4);
      esel = 8'(sel) << (2 * src);
      wr(`SEQ_IRQ_EDGE_SEL_ADDR, esel);
      rd_chk(`SEQ_IRQ_EDGE_SEL_ADDR, esel, "edge select");
      pulse(src, 1'b0);
      exp_s = ev(sel, src, 1'b1, 1'b0);
      chk("irq on fall", 8'(exp_s != 8'h00), 8'(sequence_irq_out));
      rd_chk(`SEQ_IRQ_STATUS_ADDR, exp_s, "status fall");
      chk("irq after read", 8'h00, 8'(sequence_irq_out));
      pulse(src, 1'b1);
      rd_chk(`SEQ_IRQ_STATUS_ADDR, ev(sel, src, 1'b0, 1'b1), "status rise");
    end
    wr(`SEQ_IRQ_EDGE_SEL_ADDR, 8'h55);
    wr(`SEQ_IRQ_MASK_ADDR, 8'h0F);
    pulse(0, 1'b0);
    chk("irq masked", 8'h00, 8'(sequence_irq_out));
    // in clear-on-read mode neither a status write nor the clear-all read may clear
    wr(`SEQ_IRQ_STATUS_ADDR, 8'h01);
    rd_chk(`SEQ_IRQ_CLEAR_ALL_ADDR, 8'h00, "clear all in read mode");
    rd_chk(`SEQ_IRQ_STATUS_ADDR, 8'h01, "status masked");
    pulse(0, 1'b1);
    host_u.set_ctrl(2'b00);
    wr(`SEQ_IRQ_MASK_ADDR, 8'h00);
    pulse(0, 1'b0);
    pulse(1, 1'b0);
    rd_chk(`SEQ_IRQ_STATUS_ADDR, 8'h03, "status kept on read");
    wr(`SEQ_IRQ_STATUS_ADDR, 8'h00);
    rd_chk(`SEQ_IRQ_STATUS_ADDR, 8'h03, "status write zero");
    wr(`SEQ_IRQ_STATUS_ADDR, 8'h0D);
    rd_chk(`SEQ_IRQ_STATUS_ADDR, 8'h02, "status write one");
    chk("irq pending", 8'h01, 8'(sequence_irq_out));
    rd_chk(`SEQ_IRQ_CLEAR_ALL_ADDR, 8'h00, "clear all read");
    rd_chk(`SEQ_IRQ_STATUS_ADDR, 8'h00, "status clear all");
    chk("irq released", 8'h00, 8'(sequence_irq_out));
    pulse(0, 1'b1);
    pulse(1, 1'b1);
    // second event during a set flag: kept, then dropped
    for (int m = 0; m < 2; m++) begin
      host_u.set_ctrl(2'(m));
      pulse(1, 1'b0);
      pulse(1, 1'b1);
      pulse(1, 1'b0);
      wr(`SEQ_IRQ_STATUS_ADDR, 8'h02);
      rd_chk(`SEQ_IRQ_STATUS_ADDR, (m == 0) ? 8'h02 : 8'h00, "pending event");
      wr(`SEQ_IRQ_STATUS_ADDR, 8'h02);
      pulse(1, 1'b1);
    end
    end_of_test();
  end
endmodule
`default_nettype wire
